// File: design/rep_delay_counter.sv
// down-counter that paces cycles between pieces and startup
`timescale 1ns/1ps
`include "rep_string_cfg.svh"
module rep_delay_counter
  import rep_string_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  // control
  input  wire logic        load,
  input  wire logic [15:0] load_value,
  // status
  output logic             expired
);
  logic [15:0] count_q;
  logic [15:0] count_d;

  always_comb begin
    count_d = count_q;
    if (load) begin
      count_d = load_value;
    end else if (count_q != 16'h0000) begin
      count_d = count_q - 16'h0001;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      count_q <= 16'h0000;
    end else begin
      count_q <= count_d;
    end
  end

  assign expired = (count_q == 16'h0000) && !load;
endmodule

// File: design/rep_string_cfg.svh
// timing and encoding constants for the repeated string move engine
`ifndef REP_STRING_CFG_SVH
`define REP_STRING_CFG_SVH
`define CLK_PERIOD_NS        20
`define BYTE_SHORT_LIMIT     32'h0000_0004
`define BYTE_SLOW_LIMIT      32'h0000_0009
`define WIDE_SHORT_LIMIT     32'h0000_000C
`define FAST_LIMIT           32'h0000_004C
`define LAT_BYTE_SHORT       16'h0009
`define LAT_BYTE_STARTUP     16'h0032
`define LAT_WIDE_SHORT       16'h0014
`define LAT_WIDE_MID_STARTUP 16'h000F
`define LAT_FAST_STARTUP     16'h0028
`define LAT_SPLIT_STARTUP    16'h0023
`define FAST_BEAT_CYCLES     3'h4
`define SPLIT_BEAT_CYCLES    3'h6
`define PIECE_BYTES          8'h10
`define LINE_BYTES           8'h40
`define LINE_OFFSET_MASK     8'h3F
`define PIECE_OFFSET_MASK    8'h0F
`define PIECES_PER_LINE      3'h4
`endif

// File: design/rep_string_engine.sv
// repeated string copy/fill sequencer with count-driven latency regimes
// Behaviour
// R1: each iteration moves one sized element
// R2: byte copies, count under 4: 9 cycles
// R3: byte copies, count over 9: 50 startup
// R4: wider copies, count to 12: 20 cycles
// R5: count 76+, not byte: move 16-byte pieces
// R6: fast, split-free: 40 startup, 4 per 64 bytes
// R7: line splits: 35 startup, 6 per 64 bytes
// R8: intermediate wide copies: 15 startup, one per element
// R9: fast mode allowed for unaligned addresses
// R10: count register decrements, done when zero
`timescale 1ns/1ps
`include "rep_string_cfg.svh"
module rep_string_engine
  import rep_string_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  // request from instruction execution
  input  wire logic        start,
  input  rep_req_type      req,
  output logic             busy,
  output logic             done,
  output logic [31:0]      iteration_count_reg,
  output regime_type       regime,
  // load/store path
  output logic             mem_valid,
  output mem_op_type       mem_op,
  input  wire logic        mem_ready
);
  //----------------------------------------------------------------
  // helpers
  //----------------------------------------------------------------
  function automatic logic [4:0] elem_bytes(input elem_size_type s);
    case (s)
      elem_byte:  elem_bytes = 5'h01;
      elem_word:  elem_bytes = 5'h02;
      elem_dword: elem_bytes = 5'h04;
      default:    elem_bytes = 5'h08;
    endcase
  endfunction

  function automatic regime_type pick_regime(input elem_size_type s, input logic [31:0] n);
    if (s == elem_byte) begin
      pick_regime = regime_byte;
    end else if (n <= `WIDE_SHORT_LIMIT) begin
      pick_regime = regime_short;
    end else if (n >= `FAST_LIMIT) begin
      pick_regime = regime_fast;
    end else begin
      pick_regime = regime_mid;
    end
  endfunction

  // a fast run holds at least nine pieces, so any start off a 16-byte
  // boundary walks some piece across a line edge
  function automatic logic splits(input logic [31:0] a);
    splits = (a[7:0] & `PIECE_OFFSET_MASK) != 8'h00;
  endfunction

  //----------------------------------------------------------------
  // state
  //----------------------------------------------------------------
  typedef enum logic [2:0] {
    st_idle   = 3'b000,
    st_start  = 3'b001,
    st_issue  = 3'b010,
    st_pace   = 3'b011,
    st_tail   = 3'b100,
    st_done   = 3'b101
  } state_type;

  state_type     state_q, state_d;
  rep_req_type   req_q, req_d;
  regime_type    regime_q, regime_d;
  logic          split_q, split_d;
  logic [1:0]    beat_q, beat_d;
  logic          valid_q, valid_d;
  mem_op_type    op_q, op_d;
  logic          done_q, done_d;
  logic          load;
  logic [15:0]   load_value;
  logic          expired;
  logic [4:0]    esize;
  logic          busy_q, busy_d;
  logic [4:0]    step_bytes;
  logic [31:0]   step_elems;

  rep_delay_counter u_delay (
    .clk_sys    (clk_sys),
    .reset_n    (reset_n),
    .load       (load),
    .load_value (load_value),
    .expired    (expired)
  );

  assign esize     = elem_bytes(req_q.size);

  // piece size: 16 bytes in fast mode when enough remains, else one element
  always_comb begin
    step_bytes = esize; // R1
    step_elems = 32'h0000_0001;
    if (regime_q == regime_fast) begin // R5
      if ((req_q.iteration_count_reg * {27'h0, esize}) >= {24'h0, `PIECE_BYTES}) begin
        step_bytes = 5'(`PIECE_BYTES);
        step_elems = {27'h0, 5'(`PIECE_BYTES) / esize};
      end
    end
  end

  //----------------------------------------------------------------
  // sequencer
  //----------------------------------------------------------------
  always_comb begin
    state_d    = state_q;
    req_d      = req_q;
    regime_d   = regime_q;
    split_d    = split_q;
    beat_d     = beat_q;
    valid_d    = valid_q;
    op_d       = op_q;
    done_d     = 1'b0;
    load       = 1'b0;
    load_value = 16'h0000;
    case (state_q)
      st_idle: begin
        if (start) begin
          req_d    = req;
          regime_d = pick_regime(req.size, req.iteration_count_reg);
          // unaligned addresses still qualify for fast mode
          split_d  = splits(req.src_addr) || splits(req.dst_addr); // R9
          beat_d   = 2'b00;
          load     = 1'b1;
          case (pick_regime(req.size, req.iteration_count_reg))
            regime_byte: begin
              if (req.iteration_count_reg < `BYTE_SHORT_LIMIT) begin
                load_value = `LAT_BYTE_SHORT - 16'h0002; // R2
              end else if (req.iteration_count_reg > `BYTE_SLOW_LIMIT) begin
                load_value = `LAT_BYTE_STARTUP - 16'h0001; // R3
              end else begin
                load_value = `LAT_WIDE_MID_STARTUP - 16'h0001;
              end
            end
            regime_short: load_value = `LAT_WIDE_SHORT - 16'h0002; // R4
            regime_mid:   load_value = `LAT_WIDE_MID_STARTUP - 16'h0001; // R8
            default: begin
              if (splits(req.src_addr) || splits(req.dst_addr)) begin
                load_value = `LAT_SPLIT_STARTUP - 16'h0001; // R7
              end else begin
                load_value = `LAT_FAST_STARTUP - 16'h0001; // R6
              end
            end
          endcase
          state_d = st_start;
        end
      end
      st_start: begin
        if (expired) begin
          state_d = (req_q.iteration_count_reg == 32'h0) ? st_done : st_issue;
        end
      end
      st_issue: begin
        if (!valid_q) begin
          valid_d           = 1'b1;
          op_d.is_fill      = req_q.string_fill_op;
          op_d.src_addr     = req_q.src_addr;
          op_d.dst_addr     = req_q.dst_addr;
          op_d.nbytes       = step_bytes;
          op_d.fill_value   = req_q.fill_value;
        end else if (mem_ready) begin
          valid_d                   = 1'b0;
          req_d.src_addr            = req_q.src_addr + {27'h0, step_bytes};
          req_d.dst_addr            = req_q.dst_addr + {27'h0, step_bytes};
          req_d.iteration_count_reg = req_q.iteration_count_reg - step_elems; // R10
          beat_d                    = beat_q + 2'b01;
          // other regimes spend their whole budget on the counter before the first piece
          if (regime_q == regime_fast && step_bytes == 5'(`PIECE_BYTES)) begin
            // four pieces make 64 bytes; charge one line beat at the fourth
            if (beat_q == 2'b11) begin
              load       = 1'b1;
              // the piece loop already covers the split-free line cost, so only
              // a split line pays the extra beats; never load below zero
              load_value = split_q ? {13'h0, `SPLIT_BEAT_CYCLES} - {13'h0, `FAST_BEAT_CYCLES}
                                   : 16'h0000; // R6 R7
            end
          end
          state_d = st_pace;
        end
      end
      st_pace: begin
        if (expired) begin
          state_d = (req_q.iteration_count_reg == 32'h0) ? st_done : st_issue; // R10
        end
      end
      st_done: begin
        done_d  = 1'b1; // R10
        state_d = st_idle;
      end
      default: state_d = st_idle;
    endcase
    busy_d = (state_d != st_idle);
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      state_q  <= st_idle;
      req_q    <= '0;
      regime_q <= regime_byte;
      split_q  <= 1'b0;
      beat_q   <= 2'b00;
      valid_q  <= 1'b0;
      op_q     <= '0;
      done_q   <= 1'b0;
      busy_q   <= 1'b0;
    end else begin
      state_q  <= state_d;
      req_q    <= req_d;
      regime_q <= regime_d;
      split_q  <= split_d;
      beat_q   <= beat_d;
      valid_q  <= valid_d;
      op_q     <= op_d;
      done_q   <= done_d;
      busy_q   <= busy_d;
    end
  end

  assign busy                = busy_q;
  assign done                = done_q;
  assign iteration_count_reg = req_q.iteration_count_reg;
  assign regime              = regime_q;
  assign mem_valid           = valid_q;
  assign mem_op              = op_q;
endmodule

// File: design/rep_string_pkg.sv
// types shared by the repeated string move engine
package rep_string_pkg;
  typedef enum logic [1:0] {
    elem_byte  = 2'b00,
    elem_word  = 2'b01,
    elem_dword = 2'b10,
    elem_qword = 2'b11
  } elem_size_type;

  typedef enum logic [1:0] {
    regime_byte  = 2'b00,
    regime_short = 2'b01,
    regime_mid   = 2'b10,
    regime_fast  = 2'b11
  } regime_type;

  // one request from instruction execution
  typedef struct packed {
    logic          string_fill_op;
    elem_size_type size;
    logic [31:0]   iteration_count_reg;
    logic [31:0]   src_addr;
    logic [31:0]   dst_addr;
    logic [127:0]  fill_value;
  } rep_req_type;

  // one memory piece towards the load/store path
  typedef struct packed {
    logic         is_fill;
    logic [31:0]  src_addr;
    logic [31:0]  dst_addr;
    logic [4:0]   nbytes;
    logic [127:0] fill_value;
  } mem_op_type;
endpackage

// File: tb/lsu_model.sv
// load/store path model taking pieces at once or after a stall
`timescale 1ns/1ps
module lsu_model (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic reset_n,
  // stall select and handshake
  input  wire logic slow,
  input  wire logic mem_valid,
  output logic      mem_ready
);
  logic [1:0] wait_q;
  logic [1:0] wait_d;
  always_comb begin
    wait_d = (!mem_valid || mem_ready) ? 2'h0 : wait_q + 2'h1;
  end
  always_ff @(posedge clk_sys) begin
    wait_q <= reset_n ? wait_d : 2'h0;
  end
  // a slow path holds each piece three cycles, as a cache miss would
  assign mem_ready = mem_valid && (!slow || wait_q == 2'h3);
endmodule

// File: tb/rep_string_assertions.sv
// concurrent checks on the repeated string move engine ports
`timescale 1ns/1ps
module rep_string_assertions
  import rep_string_pkg::*;
(
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        reset_n,
  // request side
  input wire logic        start,
  input rep_req_type      req,
  input wire logic        busy,
  input wire logic        done,
  input wire logic [31:0] iteration_count_reg,
  input regime_type       regime,
  // load/store side
  input wire logic        mem_valid,
  input mem_op_type       mem_op,
  input wire logic        mem_ready
);
  logic [31:0] cnt;
  assign cnt = req.iteration_count_reg;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // --------
  // request acceptance
  // --------
  sequence s_take;
    start && !busy;
  endsequence
  sequence s_wide;
    s_take ##0 req.size != elem_byte;
  endsequence
  a_byte_regime:
    assert property (s_take ##0 req.size == elem_byte |=> regime == regime_byte)
    else $error("byte regime missed");
  a_short_regime:
    assert property (s_wide ##0 cnt <= 32'h0000_000C |=> regime == regime_short)
    else $error("short regime missed");
  a_mid_regime:
    assert property (s_wide ##0 (cnt > 32'h0000_000C && cnt < 32'h0000_004C)
      |=> regime == regime_mid)
    else $error("mid regime missed");
  a_fast_regime:
    assert property (s_wide ##0 cnt >= 32'h0000_004C |=> regime == regime_fast)
    else $error("fast regime missed");
  a_small_done:
    assert property (s_take ##0 (req.size == elem_byte && cnt < 32'h0000_0004)
      |-> ##[1:60] done)
    else $error("short byte copy too slow");
  // --------
  // pieces and completion
  // --------
  a_piece_size:
    assert property (mem_valid |-> mem_op.nbytes inside {5'h01, 5'h02, 5'h04, 5'h08, 5'h10})
    else $error("bad piece size");
  a_byte_piece:
    assert property (mem_valid && regime == regime_byte |-> mem_op.nbytes == 5'h01)
    else $error("byte piece not one byte");
  a_op_hold:
    assert property (mem_valid && !mem_ready |=> mem_valid && $stable(mem_op))
    else $error("piece dropped before taken");
  a_count_drop:
    assert property (mem_valid && mem_ready
      |=> iteration_count_reg < $past(iteration_count_reg))
    else $error("count did not drop");
  a_done_empty:
    assert property (done |-> iteration_count_reg == 32'h0000_0000 ##1 !done && !busy)
    else $error("done with count left");
endmodule
bind rep_string_engine rep_string_assertions chk (.clk_sys, .reset_n, .start, .req, .busy,
  .done, .iteration_count_reg, .regime, .mem_valid, .mem_op, .mem_ready);

// File: tb/rep_string_engine_bench.sv
// self-checking bench for the repeated string move engine
`timescale 1ns/1ps
module rep_string_engine_bench
  import rep_string_pkg::*;
;
  logic        clk_sys = 1'b0;
  logic        reset_n = 1'b0;
  logic        start = 1'b0;
  logic        slow = 1'b0;
  rep_req_type req = '0;
  logic        busy, done, mem_valid, mem_ready;
  logic [31:0] iteration_count_reg;
  regime_type  regime;
  mem_op_type  mem_op;
  logic [31:0] seed = 32'h0000_ee49;
  int          num_errors = 0;
  int          checks_done = 0;
  int          cycles = 0;
  // size, count, fill, address offset, slow path
  int          tc [10][5] = '{'{0, 0, 0, 0, 0}, '{0, 3, 1, 5, 1}, '{0, 4, 0, 0, 0},
    '{0, 10, 0, 3, 1}, '{1, 12, 0, 2, 0}, '{1, 13, 1, 0, 1}, '{2, 75, 0, 4, 0},
    '{2, 76, 0, 0, 0}, '{3, 80, 1, 16, 1}, '{1, 77, 0, 58, 0}};
  rep_string_engine dut (.clk_sys, .reset_n, .start, .req, .busy, .done,
    .iteration_count_reg, .regime, .mem_valid, .mem_op, .mem_ready);
  lsu_model lsu (.clk_sys, .reset_n, .slow, .mem_valid, .mem_ready);
  always #10 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      complete_run();
    end
  end
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic check_val(input logic [127:0] got, input logic [127:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic check_lat(input int lat, input int lo, input int hi);
    checks_done++;
    if (lat < lo || lat > hi) begin
      num_errors++;
      $display("unexpected at %0t: latency %0d", $time, lat);
    end
  endtask
  task automatic complete_run();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // --------
  // one operation against the model
  // --------
  task automatic run_op(input int sz, input int cnt, input int fl, input int lo, input int sl);
    int           e, rem, off, nb, lat, su, np;
    regime_type   er;
    logic [31:0]  so, dd;
    logic [127:0] fv;
    e = 1 << sz;
    rem = cnt;
    off = 0;
    np = 0;
    lat = 0;
    seed = lfsr(seed);
    so = {seed[31:6], lo[5:0]};
    fv = {4{seed}};
    seed = lfsr(seed);
    dd = {seed[31:6], lo[5:0]};
    er = sz == 0 ? regime_byte : cnt <= 12 ? regime_short : cnt >= 76 ? regime_fast : regime_mid;
    su = sz == 0 ? (cnt < 4 ? 9 : cnt > 9 ? 50 : 15) : er == regime_short ? 20 : 15;
    if (er == regime_fast)
      su = lo % 16 != 0 ? 35 : 40;
    slow <= sl[0];
    start <= 1'b1;
    req <= '{fl[0], elem_size_type'(sz[1:0]), cnt, so, dd, fv};
    @(posedge clk_sys);
    // held high while busy: this second request must be ignored
    req.iteration_count_reg <= 32'h0000_0005;
    while (!done) begin
      @(posedge clk_sys);
      // lowered once only, so the next call may raise it in the exit time step
      if (lat == 0)
        start <= 1'b0;
      lat++;
      if (lat == 1)
        check_val(busy, 1'b1);
      if (mem_valid && mem_ready) begin
        nb = (er == regime_fast && rem * e >= 16) ? 16 : e;
        check_val({mem_op.is_fill, mem_op.nbytes, mem_op.dst_addr}, {fl[0], nb[4:0], dd + off});
        if (fl != 0)
          check_val(mem_op.fill_value, fv);
        else
          check_val(mem_op.src_addr, so + off);
        off += nb;
        rem -= nb / e;
        np++;
      end
    end
    check_val({regime, iteration_count_reg, 32'(rem), busy}, {er, 64'h0, 1'b0});
    check_lat(lat, su, su + np * (sl != 0 ? 10 : 6) + 8);
  endtask
  initial begin
    repeat (6) @(posedge clk_sys);
    reset_n <= 1'b1;
    for (int i = 0; i < 10; i++) begin
      run_op(tc[i][0], tc[i][1], tc[i][2], tc[i][3], tc[i][4]);
    end
    complete_run();
  end
endmodule
